/* File: smd_alu.sv */
// Combinational shift and move unit
`include "smd_map.svh"
module smd_alu (
    input  wire smd_pkg::smd_op_t    op_in,      // Operation
    input  wire logic [7:0]          src_in,     // File register value
    input  wire logic                carry_in,   // Present carry flag
    output smd_pkg::smd_result_t     res_out     // Result and flags
);
    function automatic logic is_zero(input logic [7:0] v);
        is_zero = (v == 8'h00);
    endfunction

    always_comb begin
        res_out.value    = src_in;
        res_out.carry    = carry_in;
        res_out.carry_we = 1'b0;
        case (op_in)
            smd_pkg::SMD_OP_LSL: begin
                res_out.value    = {src_in[6:0], 1'b0}; // RULE1 RULE3
                res_out.carry    = src_in[`SMD_MSB];    // RULE1
                res_out.carry_we = 1'b1;
            end
            smd_pkg::SMD_OP_LSR: begin
                res_out.value    = {1'b0, src_in[7:1]}; // RULE2
                res_out.carry    = src_in[0];           // RULE2
                res_out.carry_we = 1'b1;
            end
            smd_pkg::SMD_OP_MOV: begin
                res_out.value    = src_in;              // RULE5
                res_out.carry_we = 1'b0;                // RULE7
            end
            default: begin
                res_out.value    = src_in;
            end
        endcase
        res_out.zero = is_zero(res_out.value);          // RULE6 RULE7
    end
endmodule

/* File: smd_asserts.sv */
// Checker for the shift and move datapath
module smd_chk (
    input wire logic                clk_in,         // Clock
    input wire logic                rst_n_in,       // Reset
    input wire logic                valid_in,       // Execute
    input wire smd_pkg::smd_instr_t instr_in,       // Operation
    input wire logic [7:0]          file_rdata_in,  // Source
    input wire logic [6:0]          file_addr_out,  // Write address
    input wire logic                file_we_out,    // Write strobe
    input wire logic [7:0]          file_wdata_out, // Write data
    input wire logic [7:0]          wreg_out,       // W
    input wire logic                carry_out,      // Carry
    input wire logic                zero_out,       // Zero
    input wire logic                done_out        // Retired
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    logic       dst_r;
    logic [7:0] src_r;
    logic [6:0] adr_r;
    wire        lsl = valid_in && instr_in.op == smd_pkg::SMD_OP_LSL;
    wire        lsr = valid_in && instr_in.op == smd_pkg::SMD_OP_LSR;
    wire        mov = valid_in && instr_in.op == smd_pkg::SMD_OP_MOV;
    wire [7:0]  res = dst_r ? file_wdata_out : wreg_out;
    always_ff @(posedge clk_in) begin
        dst_r <= instr_in.dest;
        src_r <= file_rdata_in;
        adr_r <= instr_in.addr;
    end
    property p_lsl;
        lsl |=> res == {src_r[6:0], 1'b0} && carry_out == src_r[7];
    endproperty
    property p_lsr;
        lsr |=> res == {1'b0, src_r[7:1]} && carry_out == src_r[0];
    endproperty
    property p_ins;
        lsl && carry_out |=> !res[0];
    endproperty
    property p_dst;
        lsl || lsr |=> file_we_out == dst_r && done_out
            && (!dst_r || (file_addr_out == adr_r && $stable(wreg_out)));
    endproperty
    property p_mov;
        mov |=> res == src_r && file_we_out == dst_r;
    endproperty
    property p_mz;
        mov |=> zero_out == (src_r == 8'h00);
    endproperty
    property p_mc;
        mov |=> $stable(carry_out) && done_out;
    endproperty
    property p_sz;
        lsl || lsr |=> zero_out == (res == 8'h00);
    endproperty
    a_lsl: assert property (p_lsl) else $error("left shift wrong");
    a_lsr: assert property (p_lsr) else $error("right shift wrong");
    a_ins: assert property (p_ins) else $error("lsb not zero");
    a_dst: assert property (p_dst) else $error("shift dest wrong");
    a_mov: assert property (p_mov) else $error("move wrong");
    a_mz: assert property (p_mz) else $error("move zero wrong");
    a_mc: assert property (p_mc) else $error("move carry changed");
    a_sz: assert property (p_sz) else $error("shift zero wrong");
    c_lsl: cover property (lsl && instr_in.dest);
    c_lsr: cover property (lsr && carry_out);
    c_mov: cover property (mov && instr_in.dest);
endmodule
bind smd_datapath smd_chk chk_u (
    .clk_in         (clk_in),
    .rst_n_in       (rst_n_in),
    .valid_in       (valid_in),
    .instr_in       (instr_in),
    .file_rdata_in  (file_rdata_in),
    .file_addr_out  (file_addr_out),
    .file_we_out    (file_we_out),
    .file_wdata_out (file_wdata_out),
    .wreg_out       (wreg_out),
    .carry_out      (carry_out),
    .zero_out       (zero_out),
    .done_out       (done_out)
);

/* File: smd_datapath.sv */
// Shift and move datapath: working register, flags and file write port
// Functional notes
// RULE1: Left shift: bits up, old bit7 to carry
// RULE2: Right shift: bits down, old bit0 to carry
// RULE3: Left shift always inserts zero at LSB
// RULE4: Shift result to W if d=0, file if 1
// RULE5: Move copies file to W or back to file
// RULE6: Move updates zero flag from moved value
// RULE7: Shifts set zero on result; move keeps carry
`include "smd_map.svh"
module smd_datapath (
    input  wire logic                clk_in,          // 10 MHz core clock
    input  wire logic                rst_n_in,        // Async reset, active low
    input  wire logic                valid_in,        // Instruction executes this cycle
    input  wire smd_pkg::smd_instr_t instr_in,        // Decoded operation, address, dest
    input  wire logic [7:0]          file_rdata_in,   // Addressed file register contents
    output logic [6:0]               file_addr_out,   // File register address
    output logic                     file_we_out,     // File write strobe
    output logic [7:0]               file_wdata_out,  // File write data
    output logic [7:0]               wreg_out,        // Working register
    output logic                     carry_out,       // Carry flag
    output logic                     zero_out,        // Zero flag
    output logic                     done_out         // Operation retired
);
    smd_pkg::smd_result_t   res;
    logic [`SMD_DATA_W-1:0] w_r;
    logic [`SMD_DATA_W-1:0] w_nxt;
    logic                   c_r;
    logic                   c_nxt;
    logic                   z_r;
    logic                   z_nxt;
    logic                   fwe_r;
    logic                   fwe_nxt;
    logic [`SMD_DATA_W-1:0] fwd_r;
    logic [`SMD_DATA_W-1:0] fwd_nxt;
    logic [`SMD_ADDR_W-1:0] fad_r;
    logic [`SMD_ADDR_W-1:0] fad_nxt;
    logic                   done_r;
    logic                   done_nxt;
    logic                   act;
    logic                   to_file;
    logic                   to_wreg;

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    // Unknown codes must not touch the flags or retire, so only listed ops count
    function automatic logic op_known(input smd_pkg::smd_op_t op);
        case (op)
            smd_pkg::SMD_OP_LSL: begin
                op_known = 1'b1;
            end
            smd_pkg::SMD_OP_LSR: begin
                op_known = 1'b1;
            end
            smd_pkg::SMD_OP_MOV: begin
                op_known = 1'b1;
            end
            default: begin
                op_known = 1'b0;
            end
        endcase
    endfunction

    function automatic logic dest_is_file(input logic dest);
        dest_is_file = (dest == `SMD_DEST_F);
    endfunction

    // ----------------------------------------
    // Operation unit
    // ----------------------------------------
    smd_alu u_alu (
        .op_in    (instr_in.op),
        .src_in   (file_rdata_in),
        .carry_in (c_r),
        .res_out  (res)
    );

    // ----------------------------------------
    // Issue decode
    // ----------------------------------------
    // A file write lands one cycle later; a following op on the same address
    // reads the old value unless the host forwards the write
    assign act     = valid_in && op_known(instr_in.op);
    assign to_file = act && dest_is_file(instr_in.dest);
    assign to_wreg = act && !dest_is_file(instr_in.dest);

    // ----------------------------------------
    // Working register
    // ----------------------------------------
    always_comb begin
        w_nxt = w_r;
        if (to_wreg) begin
            w_nxt = res.value;                                // RULE4 RULE5
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            w_r <= `SMD_W_RESET;
        end else begin
            w_r <= w_nxt;
        end
    end

    // ----------------------------------------
    // Carry flag
    // ----------------------------------------
    // Only the shifts carry a new value; a move keeps the old one
    always_comb begin
        c_nxt = c_r;
        if (act && res.carry_we) begin
            c_nxt = res.carry;                                // RULE1 RULE2
        end else begin
            c_nxt = c_r;                                      // RULE7
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            c_r <= `SMD_C_RESET;
        end else begin
            c_r <= c_nxt;
        end
    end

    // ----------------------------------------
    // Zero flag
    // ----------------------------------------
    always_comb begin
        z_nxt = z_r;
        if (act) begin
            z_nxt = res.zero;                                 // RULE6 RULE7
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            z_r <= `SMD_Z_RESET;
        end else begin
            z_r <= z_nxt;
        end
    end

    // ----------------------------------------
    // File write strobe
    // ----------------------------------------
    always_comb begin
        fwe_nxt = 1'b0;
        if (to_file) begin
            fwe_nxt = 1'b1;                                   // RULE4 RULE5
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            fwe_r <= `SMD_WE_RESET;
        end else begin
            fwe_r <= fwe_nxt;
        end
    end

    // ----------------------------------------
    // File write data
    // ----------------------------------------
    // Data and address hold after the strobe so the host may sample them late
    always_comb begin
        fwd_nxt = fwd_r;
        if (to_file) begin
            fwd_nxt = res.value;                              // RULE4 RULE5
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            fwd_r <= `SMD_WDATA_RESET;
        end else begin
            fwd_r <= fwd_nxt;
        end
    end

    // ----------------------------------------
    // File write address
    // ----------------------------------------
    always_comb begin
        fad_nxt = fad_r;
        if (to_file) begin
            fad_nxt = instr_in.addr;                          // RULE4 RULE5
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            fad_r <= `SMD_WADDR_RESET;
        end else begin
            fad_r <= fad_nxt;
        end
    end

    // ----------------------------------------
    // Retire strobe
    // ----------------------------------------
    always_comb begin
        done_nxt = 1'b0;
        if (act) begin
            done_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            done_r <= `SMD_DONE_RESET;
        end else begin
            done_r <= done_nxt;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign wreg_out       = w_r;
    assign carry_out      = c_r;
    assign zero_out       = z_r;
    assign file_we_out    = fwe_r;
    assign file_wdata_out = fwd_r;
    assign file_addr_out  = fad_r;
    assign done_out       = done_r;
endmodule

/* File: smd_map.svh */
// Constants for the shift and move datapath slice
`ifndef SMD_MAP_SVH
`define SMD_MAP_SVH
`define SMD_DATA_W      8
`define SMD_ADDR_W      7
`define SMD_MSB         7
`define SMD_DEST_W      1'b0
`define SMD_DEST_F      1'b1
`define SMD_W_RESET     8'h00
`define SMD_C_RESET     1'b0
`define SMD_Z_RESET     1'b0
`define SMD_WE_RESET    1'b0
`define SMD_WDATA_RESET 8'h00
`define SMD_WADDR_RESET 7'h00
`define SMD_DONE_RESET  1'b0
`endif

/* File: smd_pkg.sv */
// Types shared by the shift and move datapath slice
package smd_pkg;
    typedef enum logic [2:0] {
        SMD_OP_NONE = 3'h0,
        SMD_OP_LSL  = 3'h1,
        SMD_OP_LSR  = 3'h2,
        SMD_OP_MOV  = 3'h4
    } smd_op_t;

    typedef struct packed {
        smd_op_t    op;
        logic [6:0] addr;
        logic       dest;
    } smd_instr_t;

    typedef struct packed {
        logic [7:0] value;
        logic       carry;
        logic       carry_we;
        logic       zero;
    } smd_result_t;
endpackage

/* File: tb.sv */
// Self-checking bench for the shift and move datapath
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 0, rst_n_in = 0, valid_in = 0;
    smd_pkg::smd_instr_t instr_in = '0;
    logic [7:0] file_rdata_in = 8'h00, file_wdata_out, wreg_out, wx = 8'h00, fx = 8'h00;
    logic [6:0] file_addr_out, ax = 7'h00;
    logic file_we_out, carry_out, zero_out, done_out;
    int failures = 0, n_compared = 0;
    smd_datapath dut_u (
        .clk_in         (clk_in),
        .rst_n_in       (rst_n_in),
        .valid_in       (valid_in),
        .instr_in       (instr_in),
        .file_rdata_in  (file_rdata_in),
        .file_addr_out  (file_addr_out),
        .file_we_out    (file_we_out),
        .file_wdata_out (file_wdata_out),
        .wreg_out       (wreg_out),
        .carry_out      (carry_out),
        .zero_out       (zero_out),
        .done_out       (done_out)
    );
    always #50 clk_in = ~clk_in;
    task cmp(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task run(input smd_pkg::smd_op_t o, input logic d, input logic [7:0] rd, r, input logic c, z);
        @(negedge clk_in);
        valid_in = 1'b1;
        instr_in = '{o, rd[6:0], d};
        file_rdata_in = rd;
        @(negedge clk_in);
        valid_in = 1'b0;
        file_rdata_in = ~rd;
        if (d) begin
            fx = r;
            ax = rd[6:0];
        end else begin
            wx = r;
        end
        cmp({4'h0, (d ? file_wdata_out : wreg_out), carry_out, zero_out, file_we_out, done_out},
            {4'h0, r, c, z, d, 1'b1});
        cmp({wreg_out, file_wdata_out}, {wx, fx});
        cmp({9'h0, file_addr_out}, {9'h0, ax});
    endtask
    task t_b2b;
        @(negedge clk_in);
        valid_in = 1'b1;
        instr_in = '{smd_pkg::SMD_OP_LSR, 7'h02, 1'b0};
        file_rdata_in = 8'h02;
        @(negedge clk_in);
        cmp({4'h0, wreg_out, carry_out, zero_out, file_we_out, done_out},
            {4'h0, 8'h01, 4'b0001});
        instr_in = '{smd_pkg::SMD_OP_LSL, 7'h40, 1'b0};
        file_rdata_in = 8'hc0;
        @(negedge clk_in);
        valid_in = 1'b0;
        cmp({4'h0, wreg_out, carry_out, zero_out, file_we_out, done_out},
            {4'h0, 8'h80, 4'b1001});
        @(negedge clk_in);
        cmp({4'h0, wreg_out, carry_out, zero_out, file_we_out, done_out},
            {4'h0, 8'h80, 4'b1000});
        wx = 8'h80;
    endtask
    task t_refuse;
        @(negedge clk_in);
        instr_in = '{smd_pkg::SMD_OP_LSR, 7'h33, 1'b1};
        file_rdata_in = 8'h00;
        @(negedge clk_in);
        cmp({4'h0, wreg_out, carry_out, zero_out, file_we_out, done_out},
            {4'h0, wx, 4'b1000});
        valid_in = 1'b1;
        instr_in.op = smd_pkg::SMD_OP_NONE;
        @(negedge clk_in);
        cmp({4'h0, wreg_out, carry_out, zero_out, file_we_out, done_out},
            {4'h0, wx, 4'b1000});
        instr_in.op = smd_pkg::smd_op_t'(3'h3);
        @(negedge clk_in);
        valid_in = 1'b0;
        cmp({4'h0, wreg_out, carry_out, zero_out, file_we_out, done_out},
            {4'h0, wx, 4'b1000});
        cmp({wreg_out, file_wdata_out}, {wx, fx});
        cmp({9'h0, file_addr_out}, {9'h0, ax});
    endtask
    task t_reset;
        @(negedge clk_in);
        rst_n_in = 1'b0;
        @(negedge clk_in);
        cmp({4'h0, wreg_out, carry_out, zero_out, file_we_out, done_out}, 16'h0000);
        cmp({wreg_out, file_wdata_out}, 16'h0000);
        cmp({9'h0, file_addr_out}, 16'h0000);
        rst_n_in = 1'b1;
        wx = 8'h00;
        fx = 8'h00;
        ax = 7'h00;
        run(smd_pkg::SMD_OP_MOV, 1'b1, 8'h5a, 8'h5a, 1'b0, 1'b0);
        run(smd_pkg::SMD_OP_LSR, 1'b0, 8'hb5, 8'h5a, 1'b1, 1'b0);
    endtask
    task t_shift;
        run(smd_pkg::SMD_OP_LSL, 1'b1, 8'h81, 8'h02, 1'b1, 1'b0);
        run(smd_pkg::SMD_OP_LSL, 1'b0, 8'h7f, 8'hfe, 1'b0, 1'b0);
        run(smd_pkg::SMD_OP_LSR, 1'b1, 8'hfe, 8'h7f, 1'b0, 1'b0);
        run(smd_pkg::SMD_OP_LSR, 1'b0, 8'h01, 8'h00, 1'b1, 1'b1);
        run(smd_pkg::SMD_OP_LSL, 1'b0, 8'h80, 8'h00, 1'b1, 1'b1);
    endtask
    task t_move;
        run(smd_pkg::SMD_OP_MOV, 1'b0, 8'h3c, 8'h3c, 1'b1, 1'b0);
        run(smd_pkg::SMD_OP_MOV, 1'b1, 8'h00, 8'h00, 1'b1, 1'b1);
    endtask
    task end_sim;
        if (failures == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #100000;
        failures++;
        end_sim;
    end
    initial begin
        repeat (4) @(negedge clk_in);
        rst_n_in = 1'b1;
        t_shift;
        t_move;
        t_b2b;
        t_refuse;
        t_reset;
        end_sim;
    end
endmodule
